//--- pkg/rivs_pkg.sv
// Package with vector addresses, source indices and widths for the vector select block
package rivs_pkg;
    localparam int RIVS_ADDR_W = 12;
    localparam int RIVS_NUM_SRC = 25;
    localparam int RIVS_IDX_W = 5;
    // Reset vector when the boot fuse is unprogrammed
    localparam logic [11:0] RIVS_RESET_ADDR = 12'h000;
    // Interrupt table base when the select bit is clear
    localparam logic [11:0] RIVS_TABLE_BASE = 12'h001;
    // Default boot reset address (boot section start), a parameter downstream
    localparam logic [11:0] RIVS_BOOT_ADDR_DEF = 12'hc00;
    // Fuse encoding: 1 unprogrammed, 0 programmed
    localparam logic RIVS_FUSE_UNPROG = 1'b1;
    localparam logic RIVS_FUSE_PROG = 1'b0;
    // Source indices: bit i of the request vector vectors to base + i
    localparam logic [4:0] RIVS_SRC_EXT0 = 5'h00;
    localparam logic [4:0] RIVS_SRC_EXT1 = 5'h01;
    localparam logic [4:0] RIVS_SRC_PCG0 = 5'h02;
    localparam logic [4:0] RIVS_SRC_PCG1 = 5'h03;
    localparam logic [4:0] RIVS_SRC_PCG2 = 5'h04;
    localparam logic [4:0] RIVS_SRC_WDTO = 5'h05;
    localparam logic [4:0] RIVS_SRC_T8B_CMPA = 5'h06;
    localparam logic [4:0] RIVS_SRC_T8B_CMPB = 5'h07;
    localparam logic [4:0] RIVS_SRC_T8B_OVF = 5'h08;
    localparam logic [4:0] RIVS_SRC_T16_CAPT = 5'h09;
    localparam logic [4:0] RIVS_SRC_T16_CMPA = 5'h0a;
    localparam logic [4:0] RIVS_SRC_T16_CMPB = 5'h0b;
    localparam logic [4:0] RIVS_SRC_T16_OVF = 5'h0c;
    localparam logic [4:0] RIVS_SRC_T8A_CMPA = 5'h0d;
    localparam logic [4:0] RIVS_SRC_T8A_CMPB = 5'h0e;
    localparam logic [4:0] RIVS_SRC_T8A_OVF = 5'h0f;
    localparam logic [4:0] RIVS_SRC_SPI_STC = 5'h10;
    localparam logic [4:0] RIVS_SRC_USART_RX = 5'h11;
    localparam logic [4:0] RIVS_SRC_USART_TXE = 5'h12;
    localparam logic [4:0] RIVS_SRC_USART_TX = 5'h13;
    localparam logic [4:0] RIVS_SRC_CONV_DONE = 5'h14;
    localparam logic [4:0] RIVS_SRC_EEPROM_RDY = 5'h15;
    localparam logic [4:0] RIVS_SRC_ACOMP = 5'h16;
    localparam logic [4:0] RIVS_SRC_TWO_WIRE = 5'h17;
    localparam logic [4:0] RIVS_SRC_SPM_RDY = 5'h18;
    // Fetch kinds
    typedef enum logic [1:0] {
        RIVS_FETCH_IDLE = 2'b00,
        RIVS_FETCH_RESET = 2'b01,
        RIVS_FETCH_IRQ = 2'b10
    } rivs_fetch_t;
endpackage

//--- src/rivs_addr.sv
// Vector address former: table base plus index
`timescale 1ns/1ps
`default_nettype none
module rivs_addr #(
    parameter int AW = 12,
    parameter int IW = 5
) (
    // Selection
    input wire logic sel_boot,
    input wire logic [AW-1:0] boot_addr,
    input wire logic [IW-1:0] idx,
    // Address out
    output logic [AW-1:0] addr
);
    import rivs_pkg::*;
    logic [AW-1:0] base;

    // Base moves into the boot section when selected; vectors one word apart
    assign base = sel_boot ? AW'(boot_addr + RIVS_TABLE_BASE) : AW'(RIVS_TABLE_BASE);
    assign addr = AW'(base + AW'(idx));
endmodule
`default_nettype wire

//--- src/rivs_pick.sv
// Lowest-index pending request finder
`timescale 1ns/1ps
`default_nettype none
module rivs_pick #(
    parameter int N = 25,
    parameter int IW = 5
) (
    // Requests
    input wire logic [N-1:0] req,
    // Result
    output logic any,
    output logic [IW-1:0] idx
);
    logic [N-1:0] found;

    // Mask each request with all lower-index requests so the lowest index wins
    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_pick
            if (g == 0) begin : g_first
                assign found[g] = req[g];
            end else begin : g_rest
                assign found[g] = req[g] & ~|req[g-1:0];
            end
        end
    endgenerate

    // Encode the one-hot winner
    always_comb begin
        idx = '0;
        for (int i = 0; i < N; i++) begin
            if (found[i]) begin
                idx = IW'(i);
            end
        end
    end

    assign any = |req;
endmodule
`default_nettype wire

//--- src/rivs_top.sv
// Reset and interrupt vector select: drives the program counter on reset and taken interrupts
//
// How it works
// RULE1 - All reset causes share one reset vector at word 0x000 when fuse unprogrammed.
// RULE2 - Programmed boot fuse starts execution at the boot reset address.
// RULE3 - Select bit set adds boot section start to every interrupt vector base.
// RULE4 - Table starts at 0x001, or boot reset address plus 0x001 when selected.
// RULE5 - Fuse value 1 means unprogrammed, 0 means programmed.
// RULE6 - External requests zero and one vector to 0x001 and 0x002.
// RULE7 - Pin change groups zero, one, two vector to 0x003, 0x004, 0x005.
// RULE8 - Watchdog timeout interrupt at 0x006, apart from watchdog reset.
// RULE9 - Second 8-bit timer compares A, B and overflow at 0x007 to 0x009.
// RULE10 - 16-bit timer capture, compares and overflow at 0x00A to 0x00D.
// RULE11 - First 8-bit timer compares A, B and overflow at 0x00E to 0x010.
// RULE12 - Serial peripheral transfer complete at 0x011.
// RULE13 - USART receive, data empty and transmit complete at 0x012 to 0x014.
// RULE14 - Converter, EEPROM, comparator, two-wire and store ready at 0x015 to 0x019.
// RULE15 - Vectors fetched only for a taken enabled interrupt.
// RULE16 - Unused slots in either section stay free for code; nothing else fetches there.
// RULE17 - Fetch address is table base plus source vector index.
`timescale 1ns/1ps
`default_nettype none
module rivs_top #(
    parameter int AW = rivs_pkg::RIVS_ADDR_W,
    parameter int N = rivs_pkg::RIVS_NUM_SRC,
    parameter logic [11:0] BOOT_ADDR = rivs_pkg::RIVS_BOOT_ADDR_DEF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Reset causes (level, any one starts a reset fetch)
    input wire logic reset_pin,
    input wire logic power_on_reset,
    input wire logic brown_out_reset,
    input wire logic watchdog_sys_reset,
    // Configuration
    input wire logic boot_reset_select_fuse,
    input wire logic vector_table_select_bit,
    // Interrupt side
    input wire logic [N-1:0] irq_pending,
    input wire logic [N-1:0] irq_enable,
    input wire logic global_irq_enable,
    input wire logic core_ready,
    // Program counter side
    output logic pc_load,
    output logic [AW-1:0] pc_addr,
    output logic irq_ack,
    output logic [rivs_pkg::RIVS_IDX_W-1:0] irq_ack_idx,
    output logic in_reset
);
    import rivs_pkg::*;

    logic any_reset;
    logic [N-1:0] irq_live;
    logic irq_any;
    logic [RIVS_IDX_W-1:0] irq_idx;
    logic [AW-1:0] vec_addr;
    logic [AW-1:0] reset_vec;
    logic take_irq;
    rivs_fetch_t kind_q;
    logic reset_seen_q;
    logic [AW-1:0] addr_q;
    logic [RIVS_IDX_W-1:0] idx_q;

    // Any of the four reset causes uses the single reset vector
    assign any_reset = reset_pin | power_on_reset | brown_out_reset | watchdog_sys_reset; // see RULE1

    // Reset vector: zero when unprogrammed, boot address when programmed
    assign reset_vec = (boot_reset_select_fuse == RIVS_FUSE_UNPROG) ? AW'(RIVS_RESET_ADDR)
                                                                    : AW'(BOOT_ADDR); // see RULE2 see RULE5

    // Only enabled sources with the global enable may be taken
    assign irq_live = global_irq_enable ? (irq_pending & irq_enable) : '0; // see RULE15

    // Index order of the request vector follows the table order
    rivs_pick #(.N(N), .IW(RIVS_IDX_W)) u_pick (
        .req(irq_live),
        .any(irq_any),
        .idx(irq_idx)
    ); // see RULE6 see RULE7 see RULE8 see RULE9 see RULE10 see RULE11 see RULE12 see RULE13 see RULE14

    // Base plus index, relocated by the select bit independent of the fuse
    rivs_addr #(.AW(AW), .IW(RIVS_IDX_W)) u_addr (
        .sel_boot(vector_table_select_bit),
        .boot_addr(AW'(BOOT_ADDR)),
        .idx(irq_idx),
        .addr(vec_addr)
    ); // see RULE3 see RULE4 see RULE17

    assign take_irq = irq_any & core_ready & ~any_reset & ~reset_seen_q;

    // Remember a reset so the first fetch after it is the reset vector
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            reset_seen_q <= 1'b1;
        end else if (any_reset) begin
            reset_seen_q <= 1'b1;
        end else if (core_ready) begin
            reset_seen_q <= 1'b0;
        end
    end

    // Fetch kind and address registers
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            kind_q <= RIVS_FETCH_IDLE;
            addr_q <= '0;
            idx_q <= '0;
        end else if (any_reset) begin
            kind_q <= RIVS_FETCH_IDLE;
        end else if (reset_seen_q && core_ready) begin
            kind_q <= RIVS_FETCH_RESET;
            addr_q <= reset_vec; // see RULE1 see RULE2
        end else if (take_irq) begin
            kind_q <= RIVS_FETCH_IRQ;
            addr_q <= vec_addr; // see RULE15 see RULE16
            idx_q <= irq_idx;
        end else begin
            kind_q <= RIVS_FETCH_IDLE;
        end
    end

    // Outputs from the registers
    always_comb begin
        pc_load = 1'b0;
        irq_ack = 1'b0;
        unique case (kind_q)
            RIVS_FETCH_IDLE: begin
                pc_load = 1'b0;
            end
            RIVS_FETCH_RESET: begin
                pc_load = 1'b1;
            end
            RIVS_FETCH_IRQ: begin
                pc_load = 1'b1;
                irq_ack = 1'b1;
            end
            default: begin
                pc_load = 1'b0;
            end
        endcase
    end

    assign pc_addr = addr_q;
    assign irq_ack_idx = idx_q;
    assign in_reset = reset_seen_q;

    // Checks
    property p_reset_vec_zero;
        @(posedge core_clk) disable iff (!nrst)
        (reset_seen_q && core_ready && !any_reset && boot_reset_select_fuse)
            |=> (kind_q == RIVS_FETCH_RESET && pc_addr == 12'h000);
    endproperty
    a_reset_vec_zero: assert property (p_reset_vec_zero) else $error("reset vector not zero"); // see RULE1

    property p_reset_vec_boot;
        @(posedge core_clk) disable iff (!nrst)
        (reset_seen_q && core_ready && !any_reset && !boot_reset_select_fuse)
            |=> (pc_load && pc_addr == BOOT_ADDR);
    endproperty
    a_reset_vec_boot: assert property (p_reset_vec_boot) else $error("boot reset address not used"); // see RULE2

    property p_table_relocate;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && vector_table_select_bit)
            |=> (pc_addr == AW'(BOOT_ADDR + 12'h001 + AW'(idx_q)));
    endproperty
    a_table_relocate: assert property (p_table_relocate) else $error("relocated vector wrong"); // see RULE3

    property p_table_base;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_idx == 5'h00) |=> (irq_ack && pc_addr == 12'h001);
    endproperty
    a_table_base: assert property (p_table_base) else $error("table base not 0x001"); // see RULE4

    property p_ext1;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[1:0] == 2'b10) |=> (pc_addr == 12'h002);
    endproperty
    a_ext1: assert property (p_ext1) else $error("external request one vector wrong"); // see RULE6

    property p_wdt;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[5:0] == 6'h20) |=> (pc_addr == 12'h006);
    endproperty
    a_wdt: assert property (p_wdt) else $error("watchdog vector wrong"); // see RULE8

    property p_last;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live == 25'h1000000) |=> (pc_addr == 12'h019);
    endproperty
    a_last: assert property (p_last) else $error("store ready vector wrong"); // see RULE14

    property p_only_enabled;
        @(posedge core_clk) disable iff (!nrst)
        irq_ack |-> (($past(irq_live) & (N'(1) << idx_q)) != '0);
    endproperty
    a_only_enabled: assert property (p_only_enabled) else $error("vector fetched without enabled source"); // see RULE15

    property p_pc_stable;
        @(posedge core_clk) disable iff (!nrst)
        !pc_load ##1 !pc_load |-> $stable(pc_addr);
    endproperty
    a_pc_stable: assert property (p_pc_stable) else $error("address moved without fetch"); // see RULE17

    // A live reset cause holds off every fetch and keeps the reset pending
    property p_cause_hold;
        @(posedge core_clk) disable iff (!nrst)
        any_reset |=> (!pc_load && in_reset);
    endproperty
    a_cause_hold: assert property (p_cause_hold) else $error("fetch during reset cause"); // see RULE1

    // Single requests in the base table land on their own slot
    property p_pcg0;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[2:0] == 3'h4) |=> (pc_addr == 12'h003);
    endproperty
    a_pcg0: assert property (p_pcg0) else $error("pin change zero vector wrong"); // see RULE7

    property p_pcg2;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[4:0] == 5'h10) |=> (pc_addr == 12'h005);
    endproperty
    a_pcg2: assert property (p_pcg2) else $error("pin change two vector wrong"); // see RULE7

    property p_t8b_cmpa;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[6:0] == 7'h40) |=> (pc_addr == 12'h007);
    endproperty
    a_t8b_cmpa: assert property (p_t8b_cmpa) else $error("second timer compare a vector wrong"); // see RULE9

    property p_t8b_ovf;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[8:0] == 9'h100) |=> (pc_addr == 12'h009);
    endproperty
    a_t8b_ovf: assert property (p_t8b_ovf) else $error("second timer overflow vector wrong"); // see RULE9

    property p_t16_capt;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[9:0] == 10'h200) |=> (pc_addr == 12'h00a);
    endproperty
    a_t16_capt: assert property (p_t16_capt) else $error("wide timer capture vector wrong"); // see RULE10

    property p_t16_ovf;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[12:0] == 13'h1000) |=> (pc_addr == 12'h00d);
    endproperty
    a_t16_ovf: assert property (p_t16_ovf) else $error("wide timer overflow vector wrong"); // see RULE10

    property p_t8a_cmpa;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[13:0] == 14'h2000) |=> (pc_addr == 12'h00e);
    endproperty
    a_t8a_cmpa: assert property (p_t8a_cmpa) else $error("first timer compare a vector wrong"); // see RULE11

    property p_t8a_ovf;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[15:0] == 16'h8000) |=> (pc_addr == 12'h010);
    endproperty
    a_t8a_ovf: assert property (p_t8a_ovf) else $error("first timer overflow vector wrong"); // see RULE11

    property p_serial_done;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[16:0] == 17'h10000) |=> (pc_addr == 12'h011);
    endproperty
    a_serial_done: assert property (p_serial_done) else $error("serial transfer vector wrong"); // see RULE12

    property p_usart_rx;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[17:0] == 18'h20000) |=> (pc_addr == 12'h012);
    endproperty
    a_usart_rx: assert property (p_usart_rx) else $error("receive complete vector wrong"); // see RULE13

    property p_usart_tx;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[19:0] == 20'h80000) |=> (pc_addr == 12'h014);
    endproperty
    a_usart_tx: assert property (p_usart_tx) else $error("transmit complete vector wrong"); // see RULE13

    property p_conv_done;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit && irq_live[20:0] == 21'h100000) |=> (pc_addr == 12'h015);
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("converter vector wrong"); // see RULE14

    // Gating: no interrupt fetch with the global enable off or the core busy
    property p_gie_off;
        @(posedge core_clk) disable iff (!nrst)
        !global_irq_enable |=> !irq_ack;
    endproperty
    a_gie_off: assert property (p_gie_off) else $error("fetch with global enable off"); // see RULE15

    property p_ready_gate;
        @(posedge core_clk) disable iff (!nrst)
        !core_ready |=> !pc_load;
    endproperty
    a_ready_gate: assert property (p_ready_gate) else $error("fetch while core not ready"); // see RULE15

    // Every load comes from a reset fetch or a taken interrupt, nothing else
    property p_no_stray_fetch;
        @(posedge core_clk) disable iff (!nrst)
        pc_load |-> $past(take_irq || (reset_seen_q && core_ready && !any_reset));
    endproperty
    a_no_stray_fetch: assert property (p_no_stray_fetch) else $error("load without a cause"); // see RULE16

    // Base table slot is the base plus the taken index
    property p_idx_slot;
        @(posedge core_clk) disable iff (!nrst)
        (take_irq && !vector_table_select_bit) |=> (pc_addr == AW'(RIVS_TABLE_BASE + AW'(idx_q)));
    endproperty
    a_idx_slot: assert property (p_idx_slot) else $error("slot not base plus index"); // see RULE17

    c_reset_fetch: cover property (@(posedge core_clk) disable iff (!nrst) kind_q == RIVS_FETCH_RESET);
    c_irq_plain: cover property (@(posedge core_clk) disable iff (!nrst) irq_ack && !vector_table_select_bit);
    c_irq_boot: cover property (@(posedge core_clk) disable iff (!nrst) irq_ack && vector_table_select_bit);
    c_boot_reset: cover property (@(posedge core_clk) disable iff (!nrst) pc_load && !irq_ack && pc_addr == BOOT_ADDR);
endmodule
`default_nettype wire

//--- verification/rivs_core_model.sv
// Core model: accepts program counter loads at full rate or every other cycle
`timescale 1ns/1ps
`default_nettype none
module rivs_core_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Mode select from the bench
    input wire logic slow,
    // Readiness towards the vector select block
    output logic core_ready
);
    logic phase_q;
    // Phase toggles every cycle so a slow core is ready only half the time
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            phase_q <= 1'b0;
        end else begin
            phase_q <= ~phase_q;
        end
    end
    // A prompt core is always ready
    assign core_ready = ~slow | phase_q;
endmodule
`default_nettype wire

//--- verification/tb_top.sv
// Self-checking bench for the reset and interrupt vector select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rivs_pkg::*;
    localparam logic [11:0] BOOT_ADDR = 12'hc00;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] cause = 4'h0;
    logic fuse = 1'b1;
    logic sel = 1'b0;
    logic [24:0] pend = 25'h0;
    logic [24:0] ena = 25'h0;
    logic gie = 1'b0;
    logic slow = 1'b0;
    logic core_ready;
    logic pc_load;
    logic irq_ack;
    logic in_reset;
    logic [11:0] pc_addr;
    logic [4:0] irq_ack_idx;
    int miscompares = 0;
    int comparisons = 0;

    // Clock at 40 MHz
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    rivs_top #(.BOOT_ADDR(BOOT_ADDR)) DUT (
        .core_clk(core_clk), .nrst(nrst),
        .reset_pin(cause[0]), .power_on_reset(cause[1]),
        .brown_out_reset(cause[2]), .watchdog_sys_reset(cause[3]),
        .boot_reset_select_fuse(fuse), .vector_table_select_bit(sel),
        .irq_pending(pend), .irq_enable(ena), .global_irq_enable(gie),
        .core_ready(core_ready), .pc_load(pc_load), .pc_addr(pc_addr),
        .irq_ack(irq_ack), .irq_ack_idx(irq_ack_idx), .in_reset(in_reset)
    );

    rivs_core_model core (.core_clk(core_clk), .nrst(nrst), .slow(slow), .core_ready(core_ready));

    task automatic give_verdict();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Move to just after the next rising edge before driving
    task automatic step();
        @(posedge core_clk);
        #2;
    endtask

    // Bounded wait for a load pulse, sampled once the edge has settled
    task automatic wait_load();
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            #1;
            n++;
        end while (pc_load !== 1'b1 && n < 40);
        if (pc_load !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask

    // Several cycles with no load allowed
    task automatic quiet(input int cycles);
        repeat (cycles) begin
            @(posedge core_clk);
            #1;
            check(12'(pc_load), 12'h000);
        end
    endtask

    // Full reset with a given fuse state, then the first fetch
    task automatic do_reset(input logic f);
        step();
        nrst = 1'b0;
        fuse = f;
        repeat (5) step();
        nrst = 1'b1;
        wait_load();
        check(pc_addr, f ? 12'h000 : BOOT_ADDR);
        check(12'(irq_ack), 12'h000);
        check(12'(in_reset), 12'h000);
        quiet(1);
    endtask

    // One source requests alone; address and index must match its slot
    task automatic take_irq(input int i, input logic [11:0] exp);
        step();
        pend = 25'h1 << i;
        wait_load();
        check(pc_addr, exp);
        check(12'(irq_ack_idx), 12'(i));
        check(12'(irq_ack), 12'h001);
        #1;
        pend = 25'h0;
        repeat (3) step();
    endtask

    // Every source with the table in either place
    task automatic scan_table(input logic s, input logic sl);
        step();
        sel = s;
        slow = sl;
        ena = '1;
        gie = 1'b1;
        for (int i = 0; i < 25; i++) begin
            take_irq(i, (s ? BOOT_ADDR + 12'h001 : 12'h001) + 12'(i));
        end
        slow = 1'b0;
    endtask

    // Disabled sources are refused, then taken once enabled
    task automatic refuse();
        step();
        ena = ~(25'h1 << 3);
        pend = 25'h1 << 3;
        quiet(6);
        #1;
        ena = '1;
        gie = 1'b0;
        quiet(6);
        #1;
        gie = 1'b1;
        wait_load();
        check(pc_addr, 12'h004);
        #1;
        pend = 25'h0;
        repeat (3) step();
    endtask

    // Two pending sources: lower slot first, then the other
    task automatic two_pending();
        step();
        pend = (25'h1 << 5) | (25'h1 << 9);
        wait_load();
        check(pc_addr, 12'h006);
        #1;
        pend = 25'h1 << 9;
        wait_load();
        check(pc_addr, 12'h00a);
        #1;
        pend = 25'h0;
        repeat (3) step();
    endtask

    // Each reset cause blocks interrupts and ends in the single reset vector
    task automatic causes();
        for (int c = 0; c < 4; c++) begin
            step();
            cause = 4'h1 << c;
            pend = 25'h1;
            quiet(3);
            check(12'(in_reset), 12'h001);
            #1;
            cause = 4'h0;
            wait_load();
            check(pc_addr, 12'h000);
            check(12'(irq_ack), 12'h000);
            #1;
            pend = 25'h0;
            repeat (3) step();
        end
    endtask

    // Remaining fuse and select pairs: table placement ignores the fuse
    task automatic mix_config();
        step();
        sel = 1'b1;
        take_irq(7, BOOT_ADDR + 12'h008);
        do_reset(1'b0);
        step();
        sel = 1'b0;
        take_irq(24, 12'h019);
    endtask

    // Main sequence
    initial begin
        do_reset(1'b0);
        scan_table(1'b1, 1'b1);
        do_reset(1'b1);
        scan_table(1'b0, 1'b0);
        refuse();
        two_pending();
        causes();
        mix_config();
        give_verdict();
    end
endmodule
`default_nettype wire
